// >>> shared/sgm_pkg.sv
// Shared constants and carrier types for the sequencer gain and diode routing bank
package sgm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STEP0_GAINS = 10'h0D4;
  localparam logic [9:0] IDX_STEP1_GAINS = 10'h0D6;
  localparam logic [9:0] IDX_STEP2_GAINS = 10'h0D8;
  localparam logic [9:0] IDX_STEP3_GAINS = 10'h0DA;
  localparam logic [9:0] IDX_ROUTE_LOW = 10'h0DC;
  localparam logic [9:0] IDX_ROUTE_HIGH = 10'h0DD;
  localparam logic [9:0] IDX_CONTROL = 10'h0F0;
  localparam int unsigned IDX_LSB = 2;
  // Reset values
  localparam logic [7:0] GAINS_RESET = 8'h88;
  localparam logic [7:0] ROUTE_LOW_RESET = 8'h66;
  localparam logic [3:0] ROUTE_HIGH_RESET = 4'h6;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  // Field positions
  localparam int unsigned CTRL_AGC_EN_BIT = 0;
  localparam int unsigned ROUTE_HIGH_W = 4;
  // Gain coding
  localparam logic [3:0] GAIN_MAX_CODE = 4'hD;
  localparam int unsigned GAIN_W = 14;
  localparam logic [GAIN_W-1:0] GAIN_HALF_UNIT = 14'h0001;
  // Routing codes of one photodiode
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_MOD0 = 2'h1;
  localparam logic [1:0] ROUTE_MOD1 = 2'h2;
  localparam int unsigned DIODES = 6;
  localparam int unsigned STEPS = 4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gain codes of one step, second modulator in the upper nibble
  typedef struct packed {
    logic [3:0] second_modulator_gain_code;
    logic [3:0] first_modulator_gain_code;
  } sgm_gain_pair_t;

  // Routing of diodes f..a, two bits each, diode a lowest
  typedef struct packed {
    logic [1:0] diode_f_routing;
    logic [1:0] diode_e_routing;
    logic [1:0] diode_d_routing;
    logic [1:0] diode_c_routing;
    logic [1:0] diode_b_routing;
    logic [1:0] diode_a_routing;
  } sgm_routing_t;
endpackage : sgm_pkg

// >>> hw/sgm_bank.sv
// Sequencer gain and photodiode routing register bank with AXI4-Lite access
// How it works
// - Step 0 gains: second nibble 7:4, first 3:0
// - Active AGC rewrites stored gains, readback shows them
// - Both modulator fields share one gain encoding
// - Steps 1-3 own gain registers, reset 0x88
// - Routing code 00 none, 01 mod0, 10 mod1
// - Step 0 diodes d,c,b,a at 7:6..1:0
// - Diodes f,e at 3:2,1:0; 7:4 reserved zero
// - Reset routes a,c,e to mod1, b,d,f mod0
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module sgm_bank #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Gain update from the automatic gain control
  input wire logic agc_upd_valid,
  input wire logic [1:0] agc_upd_step,
  input wire logic [1:0] agc_upd_mask,
  input wire sgm_pkg::sgm_gain_pair_t agc_upd_gains,
  // Sequencer step execution
  input wire logic step_exec_valid,
  input wire logic [1:0] step_exec_index,
  // Settings applied to the modulators
  output sgm_pkg::sgm_gain_pair_t applied_gains,
  output logic [sgm_pkg::GAIN_W-1:0] first_modulator_gain,
  output logic [sgm_pkg::GAIN_W-1:0] second_modulator_gain,
  output sgm_pkg::sgm_routing_t applied_routing,
  output logic [sgm_pkg::DIODES-1:0] first_modulator_diodes,
  output logic [sgm_pkg::DIODES-1:0] second_modulator_diodes,
  output logic gain_code_reserved,
  output logic route_code_reserved,
  output logic [1:0] applied_step
);

  // Gain in half units: code 0 is one half unit, each code doubles
  function automatic logic [sgm_pkg::GAIN_W-1:0] gain_decode(input logic [3:0] code);
    logic [sgm_pkg::GAIN_W-1:0] g;
    g = '0;
    if (code <= sgm_pkg::GAIN_MAX_CODE) begin // Codes above D are reserved
      g = sgm_pkg::GAIN_HALF_UNIT << code;
    end
    return g;
  endfunction : gain_decode

  // Diode mask of all diodes routed to the given code
  function automatic logic [sgm_pkg::DIODES-1:0] route_mask(
    input sgm_pkg::sgm_routing_t r,
    input logic [1:0] code
  );
    logic [sgm_pkg::DIODES*2-1:0] flat;
    logic [sgm_pkg::DIODES-1:0] m;
    flat = r;
    m = '0;
    for (int i = 0; i < sgm_pkg::DIODES; i++) begin
      m[i] = (flat[2*i +: 2] == code);
    end
    return m;
  endfunction : route_mask

  // Stored configuration
  sgm_pkg::sgm_gain_pair_t gains_q [sgm_pkg::STEPS]; // Per-step gain codes
  logic [7:0] route_low_q; // Diodes d..a of step 0
  logic [sgm_pkg::ROUTE_HIGH_W-1:0] route_high_q; // Diodes f,e of step 0
  logic agc_en_q; // Software permission for AGC rewrites

  // Bus channel state
  logic aw_held_q; // Write address taken, waiting for data
  logic w_held_q; // Write data taken, waiting for address
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Applied settings
  sgm_pkg::sgm_gain_pair_t applied_gains_q;
  logic [sgm_pkg::GAIN_W-1:0] first_gain_q;
  logic [sgm_pkg::GAIN_W-1:0] second_gain_q;
  sgm_pkg::sgm_routing_t applied_routing_q;
  logic [sgm_pkg::DIODES-1:0] first_diodes_q;
  logic [sgm_pkg::DIODES-1:0] second_diodes_q;
  logic gain_rsv_q;
  logic route_rsv_q;
  logic [1:0] applied_step_q;

  // Handshakes: one write outstanding; no new item while a response waits
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  // Write fires in the cycle both halves are present, held or taken now
  wire have_aw = aw_held_q || aw_take;
  wire have_w = w_held_q || w_take;
  wire wr_fire = have_aw && have_w;
  wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire [9:0] wr_idx = 10'(wr_addr >> sgm_pkg::IDX_LSB);
  wire [9:0] rd_idx = 10'(s_axi_araddr >> sgm_pkg::IDX_LSB);
  // Only byte lane 0 carries register bits; the other lanes are ignored
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire [7:0] wr_byte = wr_data[7:0];

  // Write decode
  wire wr_hit_gain0 = (wr_idx == sgm_pkg::IDX_STEP0_GAINS);
  wire wr_hit_gain1 = (wr_idx == sgm_pkg::IDX_STEP1_GAINS);
  wire wr_hit_gain2 = (wr_idx == sgm_pkg::IDX_STEP2_GAINS);
  wire wr_hit_gain3 = (wr_idx == sgm_pkg::IDX_STEP3_GAINS);
  wire wr_hit_rlow = (wr_idx == sgm_pkg::IDX_ROUTE_LOW);
  wire wr_hit_rhigh = (wr_idx == sgm_pkg::IDX_ROUTE_HIGH);
  wire wr_hit_ctrl = (wr_idx == sgm_pkg::IDX_CONTROL);
  wire [sgm_pkg::STEPS-1:0] wr_hit_gain = {wr_hit_gain3, wr_hit_gain2, wr_hit_gain1,
                                           wr_hit_gain0};
  wire wr_mapped = |{wr_hit_gain, wr_hit_rlow, wr_hit_rhigh, wr_hit_ctrl};

  // Read decode and mux; reserved and unused bits read zero
  wire rd_hit_gain0 = (rd_idx == sgm_pkg::IDX_STEP0_GAINS);
  wire rd_hit_gain1 = (rd_idx == sgm_pkg::IDX_STEP1_GAINS);
  wire rd_hit_gain2 = (rd_idx == sgm_pkg::IDX_STEP2_GAINS);
  wire rd_hit_gain3 = (rd_idx == sgm_pkg::IDX_STEP3_GAINS);
  wire rd_hit_rlow = (rd_idx == sgm_pkg::IDX_ROUTE_LOW);
  wire rd_hit_rhigh = (rd_idx == sgm_pkg::IDX_ROUTE_HIGH);
  wire rd_hit_ctrl = (rd_idx == sgm_pkg::IDX_CONTROL);
  wire rd_mapped = |{rd_hit_gain0, rd_hit_gain1, rd_hit_gain2, rd_hit_gain3,
                     rd_hit_rlow, rd_hit_rhigh, rd_hit_ctrl};
  wire [7:0] rd_byte =
    ({8{rd_hit_gain0}} & gains_q[0]) |
    ({8{rd_hit_gain1}} & gains_q[1]) |
    ({8{rd_hit_gain2}} & gains_q[2]) |
    ({8{rd_hit_gain3}} & gains_q[3]) |
    ({8{rd_hit_rlow}} & route_low_q) |
    ({8{rd_hit_rhigh}} & {4'h0, route_high_q}) |
    ({8{rd_hit_ctrl}} & {7'h00, agc_en_q});

  // AGC rewrite is honoured only while software leaves it enabled
  wire agc_write = agc_upd_valid && agc_en_q;

  // Step 0 routing as one carrier, diode a in the low bits
  wire [11:0] step0_route_flat = {route_high_q, route_low_q};
  sgm_pkg::sgm_routing_t step0_routing;
  assign step0_routing = step0_route_flat;

  // Routing of the executing step; only step 0 routing is held here
  sgm_pkg::sgm_routing_t exec_routing;
  assign exec_routing = (step_exec_index == 2'h0) ? step0_routing : '0;
  wire [sgm_pkg::DIODES-1:0] exec_mask0 = route_mask(exec_routing, sgm_pkg::ROUTE_MOD0);
  wire [sgm_pkg::DIODES-1:0] exec_mask1 = route_mask(exec_routing, sgm_pkg::ROUTE_MOD1);
  wire [sgm_pkg::DIODES-1:0] exec_maskn = route_mask(exec_routing, sgm_pkg::ROUTE_NONE);
  // Any diode not in none, mod0 or mod1 holds the reserved code 11
  wire exec_route_rsv = |(~(exec_mask0 | exec_mask1 | exec_maskn));
  sgm_pkg::sgm_gain_pair_t exec_gains;
  assign exec_gains = gains_q[step_exec_index];
  wire exec_gain_rsv =
    (exec_gains.first_modulator_gain_code > sgm_pkg::GAIN_MAX_CODE) ||
    (exec_gains.second_modulator_gain_code > sgm_pkg::GAIN_MAX_CODE);

  // Gain registers per step; AGC wins over a software write in the same cycle
  for (genvar s = 0; s < sgm_pkg::STEPS; s++) begin : g_gain
    wire agc_hit = agc_write && (agc_upd_step == 2'(s));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gains_q[s] <= sgm_pkg::GAINS_RESET;
      end else begin
        if (wr_lane0 && wr_hit_gain[s]) begin
          gains_q[s] <= wr_byte;
        end
        // Each field is rewritten by the AGC alone, same coding for both
        if (agc_hit && agc_upd_mask[0]) begin
          gains_q[s].first_modulator_gain_code <=
            agc_upd_gains.first_modulator_gain_code;
        end
        if (agc_hit && agc_upd_mask[1]) begin
          gains_q[s].second_modulator_gain_code <=
            agc_upd_gains.second_modulator_gain_code;
        end
      end
    end
  end

  // Step 0 routing and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_low_q <= sgm_pkg::ROUTE_LOW_RESET;
      route_high_q <= sgm_pkg::ROUTE_HIGH_RESET;
      agc_en_q <= sgm_pkg::CONTROL_RESET[sgm_pkg::CTRL_AGC_EN_BIT];
    end else begin
      if (wr_lane0 && wr_hit_rlow) begin
        route_low_q <= wr_byte;
      end
      // Upper nibble is reserved and never stored
      if (wr_lane0 && wr_hit_rhigh) begin
        route_high_q <= wr_byte[sgm_pkg::ROUTE_HIGH_W-1:0];
      end
      if (wr_lane0 && wr_hit_ctrl) begin
        agc_en_q <= wr_byte[sgm_pkg::CTRL_AGC_EN_BIT];
      end
    end
  end

  // Write channel holding registers and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= sgm_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // A lone half is parked until its partner arrives
      aw_held_q <= have_aw && !wr_fire;
      w_held_q <= have_w && !wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? sgm_pkg::RESP_OKAY : sgm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= sgm_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_mapped ? sgm_pkg::RESP_OKAY : sgm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Apply the executing step's stored settings to the modulators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_gains_q <= sgm_pkg::GAINS_RESET;
      first_gain_q <= '0;
      second_gain_q <= '0;
      applied_routing_q <= '0;
      first_diodes_q <= '0;
      second_diodes_q <= '0;
      gain_rsv_q <= 1'b0;
      route_rsv_q <= 1'b0;
      applied_step_q <= 2'h0;
    end else if (step_exec_valid) begin
      applied_gains_q <= exec_gains;
      first_gain_q <= gain_decode(exec_gains.first_modulator_gain_code);
      second_gain_q <= gain_decode(exec_gains.second_modulator_gain_code);
      applied_routing_q <= exec_routing;
      first_diodes_q <= exec_mask0;
      second_diodes_q <= exec_mask1;
      gain_rsv_q <= exec_gain_rsv;
      route_rsv_q <= exec_route_rsv;
      applied_step_q <= step_exec_index;
    end
  end

  // Port drive
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign applied_gains = applied_gains_q;
  assign first_modulator_gain = first_gain_q;
  assign second_modulator_gain = second_gain_q;
  assign applied_routing = applied_routing_q;
  assign first_modulator_diodes = first_diodes_q;
  assign second_modulator_diodes = second_diodes_q;
  assign gain_code_reserved = gain_rsv_q;
  assign route_code_reserved = route_rsv_q;
  assign applied_step = applied_step_q;

endmodule : sgm_bank
`default_nettype wire

// >>> sim/sgm_bank_monitor.sv
// Port assertions for the sequencer gain and diode routing bank
`timescale 1ns/1ps
`default_nettype none
module sgm_bank_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic step_exec_valid,
  input wire logic [1:0] step_exec_index,
  input wire sgm_pkg::sgm_gain_pair_t applied_gains,
  input wire logic [sgm_pkg::GAIN_W-1:0] first_modulator_gain,
  input wire logic [sgm_pkg::GAIN_W-1:0] second_modulator_gain,
  input wire sgm_pkg::sgm_routing_t applied_routing,
  input wire logic [sgm_pkg::DIODES-1:0] first_modulator_diodes,
  input wire logic [sgm_pkg::DIODES-1:0] second_modulator_diodes,
  input wire logic route_code_reserved,
  input wire logic [1:0] applied_step
);
  // Gain in half units; reserved codes give zero
  function automatic logic [13:0] dec(input logic [3:0] c);
    dec = (c > sgm_pkg::GAIN_MAX_CODE) ? 14'h0000 : 14'h0001 << c;
  endfunction : dec
  // Diodes whose routing field holds the given code
  function automatic logic [5:0] sel(input logic [11:0] r, input logic [1:0] c);
    for (int i = 0; i < 6; i++) sel[i] = (r[2*i +: 2] == c);
  endfunction : sel
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Decoded values are only meaningful once a step has run
  a_gain_first: assert property (
    $past(step_exec_valid) |-> first_modulator_gain == dec(applied_gains[3:0]))
    else $error("First gain value does not match its code");
  a_gain_second: assert property (
    $past(step_exec_valid) |-> second_modulator_gain == dec(applied_gains[7:4]))
    else $error("Second gain value does not match its code");
  a_step_latch: assert property (
    step_exec_valid |=> applied_step == $past(step_exec_index))
    else $error("Applied step index wrong");
  // Applied gains and step index must not drift between executions
  a_gain_hold: assert property (
    !step_exec_valid |=> $stable(applied_gains) && $stable(applied_step))
    else $error("Applied settings changed without a step");
  a_diode_first: assert property (
    $past(step_exec_valid) |->
    first_modulator_diodes == sel(applied_routing, sgm_pkg::ROUTE_MOD0))
    else $error("First modulator diode set wrong");
  a_diode_second: assert property (
    $past(step_exec_valid) |->
    second_modulator_diodes == sel(applied_routing, sgm_pkg::ROUTE_MOD1))
    else $error("Second modulator diode set wrong");
  a_route_flag: assert property (
    $past(step_exec_valid) |-> route_code_reserved == (|sel(applied_routing, 2'h3)))
    else $error("Reserved routing flag wrong");
  // A pending response blocks the next write
  a_ready_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write accepted while response pending");
  c_step_first: cover property (step_exec_valid && step_exec_index == 2'h0);
  c_step_last: cover property (step_exec_valid && step_exec_index == 2'h3);
  c_write: cover property (s_axi_bvalid);
endmodule : sgm_bank_monitor
`default_nettype wire

// >>> sim/sgm_bank_test.sv
// Self-checking testbench for the gain and routing bank
`timescale 1ns/1ps
`default_nettype none
module sgm_bank_test;
  // Bench-driven inputs, all set at time zero
  logic aclk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, agv = 1'b0, xv = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic [1:0] ags = 2'h0, agm = 2'h0, xi = 2'h0;
  logic [3:0] ws = 4'hF; // Write strobes; lane 0 off means nothing is stored
  sgm_pkg::sgm_gain_pair_t agg = 8'h00;
  // Design outputs
  logic awr, wrr, bv, arr, rv, gres, rres;
  logic [1:0] br, rr, ast;
  logic [31:0] rdd;
  sgm_pkg::sgm_gain_pair_t ag;
  sgm_pkg::sgm_routing_t rt;
  logic [13:0] g0, g1;
  logic [5:0] d0, d1;
  int bad_count = 0;
  int n_checks = 0;
  always #2 aclk = ~aclk;
  // Response ready lines held high: the master always accepts answers
  sgm_bank sgm_bank_i (
    .aclk(aclk), .aresetn(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .agc_upd_valid(agv), .agc_upd_step(ags), .agc_upd_mask(agm), .agc_upd_gains(agg),
    .step_exec_valid(xv), .step_exec_index(xi),
    .applied_gains(ag), .first_modulator_gain(g0), .second_modulator_gain(g1),
    .applied_routing(rt), .first_modulator_diodes(d0), .second_modulator_diodes(d1),
    .gain_code_reserved(gres), .route_code_reserved(rres), .applied_step(ast)
  );
  // Count a comparison, report a mismatch
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // Counts, verdict, stop
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Gain in half units, zero for reserved codes
  function automatic logic [13:0] eg(input logic [3:0] c);
    eg = (c > 4'hD) ? 14'h0000 : 14'h0001 << c;
  endfunction : eg
  // Write one register; address and data offered together
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awa <= {idx, 2'b00};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrr === 1'b1) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(1'b0, "write timeout");
      end_sim();
    end
    chk(br === er, "write response");
  endtask : wr
  // Read one register and compare the whole word
  task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(1'b0, "read timeout");
      end_sim();
    end
    chk(rdd === {24'h000000, ed} && rr === er, "read data");
  endtask : rd
  // Pulse one sequencer step, leave a cycle for outputs
  task automatic run_step(input logic [1:0] s);
    xv <= 1'b1;
    xi <= s;
    @(posedge aclk);
    xv <= 1'b0;
    @(posedge aclk);
  endtask : run_step
  // Pulse one gain-control update
  task automatic agc(input logic [1:0] s, input logic [1:0] m, input logic [7:0] g);
    agv <= 1'b1;
    ags <= s;
    agm <= m;
    agg <= g;
    @(posedge aclk);
    agv <= 1'b0;
    @(posedge aclk);
  endtask : agc
  // Reset contents, then the reset routing applied
  task automatic t_reset;
    chk(ag === 8'h88, "applied gains at reset");
    rd(sgm_pkg::IDX_STEP0_GAINS, 8'h88, 2'h0);
    rd(sgm_pkg::IDX_STEP1_GAINS, 8'h88, 2'h0);
    rd(sgm_pkg::IDX_STEP2_GAINS, 8'h88, 2'h0);
    rd(sgm_pkg::IDX_STEP3_GAINS, 8'h88, 2'h0);
    rd(sgm_pkg::IDX_ROUTE_LOW, 8'h66, 2'h0);
    rd(sgm_pkg::IDX_ROUTE_HIGH, 8'h06, 2'h0);
    run_step(2'h0);
    chk(d0 === 6'h2A && d1 === 6'h15 && g0 === 14'h0100, "reset routing");
    $display("Test reset done");
  endtask : t_reset
  // Readback, reserved bits, unmapped place
  task automatic t_regs;
    wr(sgm_pkg::IDX_STEP0_GAINS, 8'h3C, 2'h0);
    wr(sgm_pkg::IDX_STEP3_GAINS, 8'h5A, 2'h0);
    rd(sgm_pkg::IDX_STEP0_GAINS, 8'h3C, 2'h0);
    rd(sgm_pkg::IDX_STEP3_GAINS, 8'h5A, 2'h0);
    // Lane 0 strobe off: answer OKAY, register keeps its value
    ws <= 4'h0;
    wr(sgm_pkg::IDX_STEP3_GAINS, 8'hFF, 2'h0);
    ws <= 4'hF;
    rd(sgm_pkg::IDX_STEP3_GAINS, 8'h5A, 2'h0);
    run_step(2'h3);
    chk(ag === 8'h5A && ast === 2'h3 && g1 === 14'h0020 && g0 === 14'h0400, "step 3");
    wr(sgm_pkg::IDX_ROUTE_HIGH, 8'hFB, 2'h0);
    rd(sgm_pkg::IDX_ROUTE_HIGH, 8'h0B, 2'h0);
    wr(10'h0D5, 8'h12, sgm_pkg::RESP_SLVERR);
    rd(10'h0D5, 8'h00, sgm_pkg::RESP_SLVERR);
    $display("Test registers done");
  endtask : t_regs
  // Every code on both fields, swapped order, through step 1
  task automatic t_codes;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(sgm_pkg::IDX_STEP1_GAINS, {c, 4'hF - c}, 2'h0);
      run_step(2'h1);
      chk(ag === {c, 4'hF - c} && ast === 2'h1 && rt === 12'h000, "step 1");
      chk(g1 === eg(c) && g0 === eg(4'hF - c), "gain decode");
      chk(gres === (c < 4'h2 || c > 4'hD), "reserved gain flag");
    end
    $display("Test codes done");
  endtask : t_codes
  // All routing codes, including the reserved one
  task automatic t_route;
    wr(sgm_pkg::IDX_ROUTE_LOW, 8'h1B, 2'h0);
    wr(sgm_pkg::IDX_ROUTE_HIGH, 8'h09, 2'h0);
    run_step(2'h0);
    chk(rt === 12'h91B && d0 === 6'h14 && d1 === 6'h22 && rres === 1'b1, "route");
    chk(ag === 8'h3C && g1 === 14'h0008 && g0 === 14'h1000, "step 0 gains");
    wr(sgm_pkg::IDX_ROUTE_LOW, 8'h24, 2'h0);
    run_step(2'h0);
    chk(d0 === 6'h12 && d1 === 6'h24 && rres === 1'b0, "route clean");
    $display("Test routing done");
  endtask : t_route
  // Gain-control rewrites, masked, then disabled
  task automatic t_agc;
    agc(2'h2, 2'h1, 8'hC3);
    rd(sgm_pkg::IDX_STEP2_GAINS, 8'h83, 2'h0);
    agc(2'h2, 2'h2, 8'hC3);
    rd(sgm_pkg::IDX_STEP2_GAINS, 8'hC3, 2'h0);
    wr(sgm_pkg::IDX_CONTROL, 8'h00, 2'h0);
    rd(sgm_pkg::IDX_CONTROL, 8'h00, 2'h0);
    agc(2'h2, 2'h3, 8'h11);
    rd(sgm_pkg::IDX_STEP2_GAINS, 8'hC3, 2'h0);
    run_step(2'h2);
    chk(ag === 8'hC3 && ast === 2'h2 && g1 === 14'h1000 && g0 === 14'h0008, "step 2");
    wr(sgm_pkg::IDX_CONTROL, 8'h01, 2'h0);
    agc(2'h0, 2'h3, 8'h45);
    run_step(2'h0);
    chk(ag === 8'h45 && g0 === 14'h0020 && g1 === 14'h0010, "agc applied");
    $display("Test gain control done");
  endtask : t_agc
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    rst_n <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_codes();
    t_route();
    t_agc();
    end_sim();
  end
endmodule : sgm_bank_test
bind sgm_bank sgm_bank_monitor sgm_bank_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .step_exec_valid(step_exec_valid), .step_exec_index(step_exec_index),
  .applied_gains(applied_gains), .first_modulator_gain(first_modulator_gain),
  .second_modulator_gain(second_modulator_gain), .applied_routing(applied_routing),
  .first_modulator_diodes(first_modulator_diodes),
  .second_modulator_diodes(second_modulator_diodes),
  .route_code_reserved(route_code_reserved), .applied_step(applied_step)
);
`default_nettype wire
